// file: cwg_control.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - In shutdown the B override field forces B high, low, floats it, or lets it go to its source-low level, high unless polarity inverts it.
// - In shutdown the A override field does the same for pin A, except its fourth code lets A fall to its inactive level with polarity.
// - Overrides apply while shutdown status is one and until the next rising input edge after it clears, otherwise outputs follow the dead-banded waveform.
// - The source select field picks logic cell one, the oscillator or one of four pulse channels, codes 0 and 1 reserved.
// - Shutdown status reads one after a shutdown event and zero when none.
// - Auto-restart enable lets shutdown end by itself, else software must end it.
// - With the fault enable set, a low fault pin causes shutdown.
// - With the logic cell enable set, a high logic cell two output causes shutdown.
// - Rising dead-band count N delays the rising edge N to N+1 counts, upper bits read zero.
// - Falling dead-band count N delays the falling edge N to N+1 counts, upper bits read zero.
// - A falling count of zero bypasses the dead-band path.
// - Override fields are not reset, source select and bit 3 reset to zero, shutdown register resets to zero.
// - With auto-restart the status clears once sources go quiet, overrides hold until the next rising input edge.
// - Writing one to status forces shutdown, clearing by software only works with all sources quiet.
// - Shutdown sources are level sensitive and hold the status while active and enabled.
module cwg_control (
    input wire logic clock, // 40 MHz system clock
    input wire logic rstn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic pulse_channel_one_output, // Pulse channel 1
    input wire logic pulse_channel_two_output, // Pulse channel 2
    input wire logic pulse_channel_three_output, // Pulse channel 3
    input wire logic pulse_channel_four_output, // Pulse channel 4
    input wire logic oscillator_source_output, // Oscillator output
    input wire logic logic_cell_one_output, // Logic cell 1 output
    input wire logic logic_cell_two_output, // Logic cell 2 output
    input wire logic fault_input_pin, // Fault pin, active low
    input wire logic internal_fast_oscillator, // Fast osc tick enable
    output logic output_a_pin, // Pin A level
    output logic output_a_oe, // Pin A driven when high
    output logic output_b_pin, // Pin B level
    output logic output_b_oe // Pin B driven when high
);
    import cwg_pkg::*;

    function automatic logic [1:0] pin_drive(
        input logic [1:0] ov,
        input logic active,
        input logic path,
        input logic inv,
        input logic oe_bit
    );
        logic [1:0] r;
        r = {oe_bit, path ^ inv};
        if (active)
        begin
            unique case (ov)
                CWG_OV_HIGH: r = {oe_bit, 1'b1};
                CWG_OV_LOW: r = {oe_bit, 1'b0};
                CWG_OV_TRISTATE: r = {1'b0, 1'b0};
                CWG_OV_INACTIVE: r = {oe_bit, path ^ inv};
            endcase
        end
        return r;
    endfunction

    // Register address match, shared by every register
    function automatic logic reg_hit(
        input logic [11:0] addr,
        input logic [11:0] ofs
    );
        return addr == ofs;
    endfunction

    // Dead-band count readback, upper bits read zero
    function automatic logic [7:0] db_byte(
        input logic [CWG_DB_W-1:0] n
    );
        return {2'h0, n};
    endfunction

    // Register storage
    logic [7:0] ctrl0;
    logic [1:0] ov_b;
    logic [1:0] ov_a;
    logic [2:0] src_sel;
    logic shutdown_status;
    logic auto_restart_en;
    logic fault_pin_shutdown_en;
    logic logic_cell_shutdown_en;
    logic [CWG_DB_W-1:0] rise_delay_count;
    logic [CWG_DB_W-1:0] fall_delay_count;

    // Run state
    logic override_hold;
    logic src_q;
    logic [1:0] next_a;
    logic [1:0] next_b;

    // APB decode
    wire logic setup_ph = psel && !penable;
    wire logic access_ph = psel && penable;
    wire logic hit_c0 = reg_hit(paddr, CWG_OFS_CON0);
    wire logic hit_c1 = reg_hit(paddr, CWG_OFS_CON1);
    wire logic hit_c2 = reg_hit(paddr, CWG_OFS_CON2);
    wire logic hit_dbr = reg_hit(paddr, CWG_OFS_DBR);
    wire logic hit_dbf = reg_hit(paddr, CWG_OFS_DBF);
    wire logic hit_any = hit_c0 || hit_c1 || hit_c2 || hit_dbr || hit_dbf;
    wire logic wr_ok = access_ph && pwrite && hit_any;
    wire logic [7:0] wbyte = pwdata[7:0];

    wire logic [7:0] rd_c1 = {ov_b, ov_a, 1'b0, src_sel};
    wire logic [7:0] rd_c2 = {shutdown_status, auto_restart_en, 4'h0,
        fault_pin_shutdown_en, logic_cell_shutdown_en};
    wire logic [7:0] rd_byte =
        hit_c0 ? (ctrl0 & CWG_C0_MASK) :
        hit_c1 ? rd_c1 :
        hit_c2 ? rd_c2 :
        hit_dbr ? db_byte(rise_delay_count) :
        hit_dbf ? db_byte(fall_delay_count) :
        8'h00;

    assign pready = 1'b1;

    // Read data and error are captured in the setup phase
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= !hit_any;
        end
    end

    // Control register 0
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ctrl0 <= CWG_C0_RST;
        else if (wr_ok && hit_c0)
            ctrl0 <= wbyte & CWG_C0_MASK;
    end

    wire logic module_enable = ctrl0[CWG_C0_EN];
    wire logic output_a_invert = ctrl0[CWG_C0_POLA];
    wire logic output_b_invert = ctrl0[CWG_C0_POLB];
    wire logic clock_source_sel = ctrl0[CWG_C0_CS];

    // Override fields keep their value across reset
    always_ff @(posedge clock)
    begin
        if (wr_ok && hit_c1)
        begin
            ov_b <= wbyte[CWG_C1_OVB_LO +: 2];
            ov_a <= wbyte[CWG_C1_OVA_LO +: 2];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            src_sel <= CWG_C1_SRC_RST;
        else if (wr_ok && hit_c1)
            src_sel <= wbyte[CWG_C1_SRC_LO +: 3];
    end

    // Shutdown sources, level sensitive
    wire logic fault_act = fault_pin_shutdown_en && !fault_input_pin;
    wire logic lc_act = logic_cell_shutdown_en
        && logic_cell_two_output;
    wire logic src_act = fault_act || lc_act;
    wire logic c2_wr = wr_ok && hit_c2;
    wire logic sw_set = c2_wr && wbyte[CWG_C2_STAT];
    wire logic sw_clr = c2_wr && !wbyte[CWG_C2_STAT] && !src_act;
    wire logic auto_clr = auto_restart_en && !src_act;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            auto_restart_en <= CWG_C2_RST[CWG_C2_ARS];
            fault_pin_shutdown_en <= CWG_C2_RST[CWG_C2_FLT];
            logic_cell_shutdown_en <= CWG_C2_RST[CWG_C2_LC2];
        end
        else if (c2_wr)
        begin
            auto_restart_en <= wbyte[CWG_C2_ARS];
            fault_pin_shutdown_en <= wbyte[CWG_C2_FLT];
            logic_cell_shutdown_en <= wbyte[CWG_C2_LC2];
        end
    end

    // Setting always wins over any clear
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            shutdown_status <= CWG_C2_RST[CWG_C2_STAT];
        else if (src_act || sw_set)
            shutdown_status <= 1'b1;
        else if (sw_clr || auto_clr)
            shutdown_status <= 1'b0;
    end

    // Dead-band registers
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rise_delay_count <= CWG_DB_RST;
            fall_delay_count <= CWG_DB_RST;
        end
        else if (wr_ok && hit_dbr)
            rise_delay_count <= wbyte[CWG_DB_W-1:0];
        else if (wr_ok && hit_dbf)
            fall_delay_count <= wbyte[CWG_DB_W-1:0];
    end

    // Modulation source select
    logic src_raw;
    always_comb
    begin
        unique case (cwg_source_t'(src_sel))
            CWG_SRC_LC1: src_raw = logic_cell_one_output;
            CWG_SRC_OSC: src_raw = oscillator_source_output;
            CWG_SRC_PWM4: src_raw = pulse_channel_four_output;
            CWG_SRC_PWM3: src_raw = pulse_channel_three_output;
            CWG_SRC_PWM2: src_raw = pulse_channel_two_output;
            CWG_SRC_PWM1: src_raw = pulse_channel_one_output;
            CWG_SRC_RSV1: src_raw = 1'b0;
            CWG_SRC_RSV0: src_raw = 1'b0;
        endcase
    end

    wire logic src_in = module_enable && src_raw;
    wire logic src_rise = src_in && !src_q;
    wire logic ov_active = shutdown_status || override_hold;

    // Overrides persist after clearing until a rising input edge
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            src_q <= 1'b0;
            override_hold <= 1'b0;
        end
        else
        begin
            src_q <= src_in;
            if (shutdown_status)
                override_hold <= 1'b1;
            else if (src_rise)
                override_hold <= 1'b0;
        end
    end

    // Dead-band paths; waveform held low while overridden
    wire logic wave = src_in && !ov_active;
    wire logic count_en = clock_source_sel ? internal_fast_oscillator : 1'b1;

    cwg_dly_if rise_if ();
    cwg_dly_if fall_if ();

    assign rise_if.level_in = wave;
    assign rise_if.count = rise_delay_count;
    assign rise_if.count_en = count_en;
    assign fall_if.level_in = module_enable && !wave;
    assign fall_if.count = fall_delay_count;
    assign fall_if.count_en = count_en;

    cwg_dead_band u_rise (
        .clock(clock),
        .rstn(rstn),
        .dl(rise_if.dly)
    );

    cwg_dead_band u_fall (
        .clock(clock),
        .rstn(rstn),
        .dl(fall_if.dly)
    );

    // Pin level and enable per override field
    assign next_a = pin_drive(ov_a, ov_active, rise_if.delayed_out,
        output_a_invert, ctrl0[CWG_C0_OEA] && module_enable);
    assign next_b = pin_drive(ov_b, ov_active, fall_if.delayed_out,
        output_b_invert, ctrl0[CWG_C0_OEB] && module_enable);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            output_a_pin <= 1'b0;
            output_a_oe <= 1'b0;
            output_b_pin <= 1'b0;
            output_b_oe <= 1'b0;
        end
        else
        begin
            output_a_pin <= next_a[0];
            output_a_oe <= next_a[1];
            output_b_pin <= next_b[0];
            output_b_oe <= next_b[1];
        end
    end
endmodule
`default_nettype wire

// file: cwg_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cwg_control_checker
    import cwg_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rstn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic fault_input_pin, // Fault
    input wire logic logic_cell_two_output, // Cell two
    input wire logic output_a_pin, // Pin A
    input wire logic output_a_oe, // A enable
    input wire logic output_b_pin, // Pin B
    input wire logic output_b_oe // B enable
);
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    wire wr = psel && penable && pwrite;
    wire rd = psel && !penable && !pwrite;
    wire sd = (c2[1] && !fault_input_pin) || (c2[0] && logic_cell_two_output);
    wire oe_a = c0[7] && c0[5];
    wire oe_b = c0[7] && c0[6];

    // Shadow of the written control bits
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            c0 <= 8'h00;
            c1[3:0] <= 4'h0;
            c2 <= 8'h00;
        end
        else if (wr)
        begin
            if (paddr == CWG_OFS_CON0) c0 <= pwdata[7:0];
            if (paddr == CWG_OFS_CON1) c1 <= pwdata[7:0];
            if (paddr == CWG_OFS_CON2) c2 <= pwdata[7:0];
        end
    end

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rstn);

    chk_ovr_b_high: assert property (
        (sd && c1[7:6] == 2'h3 && oe_b)[*3] |-> output_b_pin && output_b_oe)
        else $error("B not forced high");
    chk_ovr_a_low: assert property (
        (sd && c1[5:4] == 2'h2 && oe_a)[*3] |-> !output_a_pin && output_a_oe)
        else $error("A not forced low");
    chk_ovr_a_float: assert property (
        (sd && c1[5:4] == 2'h1)[*3] |-> !output_a_oe)
        else $error("A not floated");
    chk_src_reserved: assert property (
        (oe_a && c1[5:1] == 5'h00)[*4] |-> output_a_pin == c0[3])
        else $error("A active on reserved source");
    chk_rise_upper: assert property (
        rd && paddr == CWG_OFS_DBR |=> prdata[31:6] == 26'h0)
        else $error("rise count upper bits set");
    chk_fall_upper: assert property (
        rd && paddr == CWG_OFS_DBF |=> prdata[31:6] == 26'h0)
        else $error("fall count upper bits set");
    chk_sd_readback: assert property (
        rd && paddr == CWG_OFS_CON2 |=> prdata[6:0] == {c2[6], 4'h0, c2[1:0]})
        else $error("shutdown control readback wrong");
    chk_src_readback: assert property (
        rd && paddr == CWG_OFS_CON1 |=> prdata[3:0] == {1'b0, c1[2:0]})
        else $error("source select readback wrong");

    cover property (sd && c1[7:6] == 2'h3);
    cover property (c1[2:0] == 3'h7 && output_a_pin);
    cover property (sd && c1[5:4] == 2'h1);
endmodule
bind cwg_control cwg_control_checker i_cwg_control_checker (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .fault_input_pin, .logic_cell_two_output, .output_a_pin,
    .output_a_oe, .output_b_pin, .output_b_oe
);
`default_nettype wire

// file: cwg_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cwg_control_tb_top;
    import cwg_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [5:0] srcv = 6'h00;
    logic lc2 = 1'b0;
    logic flt = 1'b1;
    logic fosc = 1'b0;
    logic fosc_run = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pa, aoe, pb, boe, ga, gb, er;
    logic [7:0] rv;
    int bad_count = 0;
    int samples_checked = 0;
    int k;

    always #12.5 clock = ~clock;

    // Fast oscillator ticks every other clock while running
    always @(posedge clock)
        fosc <= fosc_run && !fosc;

    cwg_control i_cwg_control (
        .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pulse_channel_one_output(srcv[0]),
        .pulse_channel_two_output(srcv[1]),
        .pulse_channel_three_output(srcv[2]),
        .pulse_channel_four_output(srcv[3]),
        .oscillator_source_output(srcv[4]),
        .logic_cell_one_output(srcv[5]), .logic_cell_two_output(lc2),
        .fault_input_pin(flt), .internal_fast_oscillator(fosc),
        .output_a_pin(pa), .output_a_oe(aoe), .output_b_pin(pb),
        .output_b_oe(boe)
    );
    cwg_gate_drv i_cwg_gate_drv (.a_level(pa), .a_oe(aoe), .b_level(pb),
        .b_oe(boe), .gate_a(ga), .gate_b(gb));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wt, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wt;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rv = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rv, e);
    endtask

    task automatic nw(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Negedges from a source change until the pin goes high
    task automatic meas(input logic b);
        k = 0;
        do
        begin
            @(negedge clock);
            k++;
        end
        while ((b ? pb : pa) !== 1'b1 && k < 100);
    endtask

    task automatic drv_src(input logic [5:0] v);
        @(posedge clock);
        srcv <= v;
    endtask

    task automatic t_reset;
        rdc(CWG_OFS_CON2, 8'h00);
        xfer(1'b0, CWG_OFS_CON1, 8'h00);
        chk(rv[3:0], 4'h0);
        xfer(1'b0, 12'h020, 8'h00);
        chk({er, rv}, 9'h100);
    endtask

    task automatic t_src;
        wr(CWG_OFS_CON0, 8'hE0);
        for (int c = 0; c < 8; c++)
        begin
            wr(CWG_OFS_CON1, 8'(c));
            srcv <= (c < 2) ? 6'h3F : 6'(6'h01 << (c - 2));
            nw(6);
            chk({pa, pb}, (c < 2) ? 2'h1 : 2'h2);
            drv_src(6'h00);
            nw(6);
        end
    endtask

    task automatic t_dly;
        wr(CWG_OFS_DBR, 8'hFF);
        rdc(CWG_OFS_DBR, 8'h3F);
        wr(CWG_OFS_DBF, 8'hC0);
        rdc(CWG_OFS_DBF, 8'h00);
        wr(CWG_OFS_CON1, 8'h02);
        drv_src(6'h01);
        meas(1'b0);
        chk(k >= 66 && k <= 67, 1'b1);
        drv_src(6'h00);
        meas(1'b1);
        chk(k, 32'h00000003);
        wr(CWG_OFS_DBF, 8'h01);
        drv_src(6'h01);
        nw(70);
        drv_src(6'h00);
        meas(1'b1);
        chk(k >= 4 && k <= 5, 1'b1);
        wr(CWG_OFS_DBR, 8'h00);
    endtask

    // Counts advance only on fast oscillator ticks when it is selected
    task automatic t_tick;
        wr(CWG_OFS_DBR, 8'h04);
        wr(CWG_OFS_CON0, 8'hE1);
        fosc_run <= 1'b1;
        drv_src(6'h01);
        meas(1'b0);
        chk(k >= 11 && k <= 12, 1'b1);
        drv_src(6'h00);
        fosc_run <= 1'b0;
        nw(4);
        drv_src(6'h01);
        nw(20);
        chk(pa, 1'b0);
        wr(CWG_OFS_CON0, 8'hE0);
        wr(CWG_OFS_DBR, 8'h00);
    endtask

    task automatic t_fault;
        wr(CWG_OFS_CON1, 8'hE2);
        flt <= 1'b0;
        srcv <= 6'h01;
        nw(4);
        rdc(CWG_OFS_CON2, 8'h00);
        wr(CWG_OFS_CON2, 8'h02);
        nw(3);
        chk({ga, aoe, gb, boe}, 4'h7);
        rdc(CWG_OFS_CON2, 8'h82);
        wr(CWG_OFS_CON2, 8'h02);
        rdc(CWG_OFS_CON2, 8'h82);
        flt <= 1'b1;
        nw(3);
        rdc(CWG_OFS_CON2, 8'h82);
        wr(CWG_OFS_CON2, 8'h02);
        rdc(CWG_OFS_CON2, 8'h02);
        nw(4);
        chk(ga, 1'b0);
        drv_src(6'h00);
        nw(4);
        drv_src(6'h01);
        nw(6);
        chk(ga, 1'b1);
        wr(CWG_OFS_CON2, 8'h80);
        nw(3);
        chk({ga, gb}, 2'h1);
        wr(CWG_OFS_CON2, 8'h00);
        rdc(CWG_OFS_CON2, 8'h00);
    endtask

    task automatic t_lc2;
        wr(CWG_OFS_CON0, 8'hF0);
        wr(CWG_OFS_CON1, 8'h12);
        wr(CWG_OFS_CON2, 8'h41);
        drv_src(6'h00);
        nw(4);
        drv_src(6'h01);
        nw(6);
        chk(gb, 1'b1);
        @(posedge clock);
        lc2 <= 1'b1;
        nw(8);
        chk({aoe, gb}, 2'h0);
        rdc(CWG_OFS_CON2, 8'hC1);
        lc2 <= 1'b0;
        nw(3);
        rdc(CWG_OFS_CON2, 8'h41);
        wr(CWG_OFS_CON2, 8'h40);
        lc2 <= 1'b1;
        nw(3);
        rdc(CWG_OFS_CON2, 8'h40);
        lc2 <= 1'b0;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_reset;
        t_src;
        t_dly;
        t_tick;
        t_fault;
        t_lc2;
        complete_run;
    end

    initial
    begin
        #500000;
        bad_count++;
        complete_run;
    end
endmodule
`default_nettype wire

// file: cwg_dead_band.sv
`timescale 1ns/1ps
`default_nettype none
module cwg_dead_band (
    input wire logic clock, // System clock
    input wire logic rstn, // Async reset, active low
    cwg_dly_if.dly dl // Level in, count, delayed level out
);
    import cwg_pkg::*;

    logic [CWG_DB_W-1:0] cnt;
    logic out_q;
    wire logic bypass = (dl.count == '0);
    wire logic done = (cnt == dl.count);

    assign dl.delayed_out = out_q;

    // Assertion of the level is delayed, release is immediate
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= '0;
            out_q <= 1'b0;
        end
        else if (!dl.level_in)
        begin
            cnt <= '0;
            out_q <= 1'b0;
        end
        else if (bypass)
            out_q <= 1'b1;
        else if (!out_q && dl.count_en)
        begin
            if (done)
                out_q <= 1'b1;
            else
                cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: cwg_dly_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cwg_dly_if;
    import cwg_pkg::*;
    logic level_in;
    logic [CWG_DB_W-1:0] count;
    logic count_en;
    logic delayed_out;
    modport ctrl (output level_in, output count, output count_en,
        input delayed_out);
    modport dly (input level_in, input count, input count_en,
        output delayed_out);
endinterface
`default_nettype wire

// file: cwg_gate_drv.sv
`timescale 1ns/1ps
`default_nettype none
module cwg_gate_drv (
    input wire logic a_level, // Pin A level
    input wire logic a_oe, // Pin A driven
    input wire logic b_level, // Pin B level
    input wire logic b_oe, // Pin B driven
    output logic gate_a, // Gate input A
    output logic gate_b // Gate input B
);
    // Pull-downs turn a floating gate off
    assign gate_a = a_oe ? a_level : 1'b0;
    assign gate_b = b_oe ? b_level : 1'b0;
endmodule
`default_nettype wire

// file: cwg_pkg.sv
`default_nettype none
package cwg_pkg;
    // Register byte offsets on the bus
    localparam logic [11:0] CWG_OFS_CON0 = 12'h000;
    localparam logic [11:0] CWG_OFS_CON1 = 12'h004;
    localparam logic [11:0] CWG_OFS_CON2 = 12'h008;
    localparam logic [11:0] CWG_OFS_DBR = 12'h00C;
    localparam logic [11:0] CWG_OFS_DBF = 12'h010;

    // enable_polarity_clock_control fields
    localparam int CWG_C0_EN = 7;
    localparam int CWG_C0_OEB = 6;
    localparam int CWG_C0_OEA = 5;
    localparam int CWG_C0_POLB = 4;
    localparam int CWG_C0_POLA = 3;
    localparam int CWG_C0_CS = 0;
    localparam logic [7:0] CWG_C0_MASK = 8'hF9;
    localparam logic [7:0] CWG_C0_RST = 8'h00;

    // source_and_override_control fields
    localparam int CWG_C1_OVB_LO = 6;
    localparam int CWG_C1_OVA_LO = 4;
    localparam int CWG_C1_SRC_LO = 0;
    localparam logic [2:0] CWG_C1_SRC_RST = 3'h0;

    // shutdown_control_status fields
    localparam int CWG_C2_STAT = 7;
    localparam int CWG_C2_ARS = 6;
    localparam int CWG_C2_FLT = 1;
    localparam int CWG_C2_LC2 = 0;
    localparam logic [7:0] CWG_C2_RST = 8'h00;

    // Dead-band counters
    localparam int CWG_DB_W = 6;
    localparam logic [5:0] CWG_DB_RST = 6'h00;

    typedef enum logic [1:0] {
        CWG_OV_INACTIVE = 2'h0,
        CWG_OV_TRISTATE = 2'h1,
        CWG_OV_LOW = 2'h2,
        CWG_OV_HIGH = 2'h3
    } cwg_override_t;

    typedef enum logic [2:0] {
        CWG_SRC_RSV0 = 3'h0,
        CWG_SRC_RSV1 = 3'h1,
        CWG_SRC_PWM1 = 3'h2,
        CWG_SRC_PWM2 = 3'h3,
        CWG_SRC_PWM3 = 3'h4,
        CWG_SRC_PWM4 = 3'h5,
        CWG_SRC_OSC = 3'h6,
        CWG_SRC_LC1 = 3'h7
    } cwg_source_t;
endpackage
`default_nettype wire
